// file: core/sensor_status_fifo_regs.sv
// Status, result and FIFO register section with APB access
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Command failure sets flag, read clears
// - Config error flagged only in normal mode
// - Ready bit shows command decoder idle
// - Pressure ready cleared by pressure byte read
// - Temperature ready cleared by temperature read
// - Pressure result low byte first
// - Temperature result low byte first
// - Sensor time low byte first
// - Power-up flag set, cleared on read
// - Access during conversion flag, read clears
// - Interrupt status bits, whole register read-clears
// - Fill counter split low and high
// - Read port pops next byte
// - Samples stored only with FIFO enabled
// - Stop-on-full drops, else overwrite oldest
// - Time frame after last data frame
// - Pressure stored only when enabled
// - Temperature stored only when enabled
// - Subsample by two to field power
// - Source select, code one filtered
// - Mode three is normal mode
// - Watermark flag needs its enable
module sensor_status_fifo_regs #(
  parameter int         DEPTH    = 512,    // FIFO bytes
  parameter logic [7:0] REVISION = 8'h5A   // Arbitrary revision code
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [9:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Sensor core side
  input  wire sensor_regs_pkg::sensor_in_t sens,
  output logic      [2:0]                  irq_flags
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  cmd_err;  // Sticky command failure
    logic                  conf_err; // Sticky configuration error
    logic                  drdy_p;   // Pressure result ready
    logic                  drdy_t;   // Temperature result ready
    logic                  por;      // Power-up seen
    logic                  act;      // Access during conversion
    logic [2:0]            irq;      // Watermark, full, data ready
    logic [23:0]           press;    // Pressure result
    logic [23:0]           temp;     // Temperature result
    logic [8:0]            wtm;      // Watermark level
    logic [4:0]            cfg1;     // Frame content setup
    logic [4:0]            cfg2;     // Subsampling and source
    logic [8:0]            rd;       // Read pointer
    logic [8:0]            wr;       // Write pointer
    logic [9:0]            cnt;      // Fill level, up to DEPTH
    logic [6:0]            sub;      // Subsampling counter
    sensor_regs_pkg::seq_t seq;      // Frame push sequencer
    logic [55:0]           frame;    // Frame bytes, first in low byte
    logic [2:0]            flen;     // Frame length in bytes
    logic [2:0]            fidx;     // Next frame byte
    logic [2:0]            tidx;     // Time frame progress
    logic [31:0]           prdata;   // Read data to bus
    logic                  slverr;   // Error answer to bus
  } state_t;

  state_t      s_q;     // Registered state
  state_t      s_d;     // Next state
  logic [7:0]  mem [DEPTH]; // FIFO storage
  logic        we;      // Storage write strobe
  logic [7:0]  wdat;    // Storage write byte

  logic [7:0]  idx;     // Register index
  logic        known;   // Index is mapped
  logic        setup;   // APB setup cycle
  logic        rd_acc;  // Completing read
  logic        wr_acc;  // Completing write

  logic        pop;     // Byte leaves FIFO
  logic        push;    // Byte enters FIFO
  logic        full;    // FIFO at capacity
  logic        ovw;     // Push replaces oldest byte

  logic        sample;  // Any new result
  logic        use_p;   // Pressure goes to frame
  logic        use_t;   // Temperature goes to frame
  logic        filt;    // Filtered source chosen
  logic [23:0] fp;      // Pressure for frame
  logic [23:0] ft;      // Temperature for frame
  logic [6:0]  msk;     // Subsampling mask

  logic [7:0]  rb;      // Byte for current read
  logic [7:0]  port_b;  // Byte the read port returns

  // Handshake is zero-wait: the access cycle always completes
  assign pready    = psel & penable;
  assign prdata    = s_q.prdata;
  assign pslverr   = s_q.slverr & psel & penable;
  assign irq_flags = s_q.irq;

  // ----------------------------------------------------------------
  // Read port byte: data, then one time frame, then empty marker
  // ----------------------------------------------------------------
  always_comb begin
    if (s_q.cnt != 10'h000) begin
      port_b = mem[s_q.rd];
    end else if (s_q.cfg1[sensor_regs_pkg::C1_TIME] &&
                 s_q.tidx != sensor_regs_pkg::TIME_DONE) begin
      unique case (s_q.tidx)
        3'h0:    port_b = sensor_regs_pkg::HDR_TIME;
        3'h1:    port_b = sens.time_count[7:0];
        3'h2:    port_b = sens.time_count[15:8];
        default: port_b = sens.time_count[23:16];
      endcase
    end else begin
      port_b = sensor_regs_pkg::BYTE_EMPTY;
    end
  end

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    idx   = paddr[9:2];
    known = (paddr[1:0] == 2'h0);
    rb    = 8'h00;

    unique case (idx)
      sensor_regs_pkg::IDX_REV:   rb = REVISION;
      sensor_regs_pkg::IDX_ERR:   rb = {5'h00, s_q.conf_err, s_q.cmd_err, sens.fatal};
      sensor_regs_pkg::IDX_FLAGS: rb = {1'b0, s_q.drdy_t, s_q.drdy_p, ~sens.cmd_busy,
                                        4'h0};
      sensor_regs_pkg::IDX_P0:    rb = s_q.press[7:0];
      sensor_regs_pkg::IDX_P1:    rb = s_q.press[15:8];
      sensor_regs_pkg::IDX_P2:    rb = s_q.press[23:16];
      sensor_regs_pkg::IDX_T0:    rb = s_q.temp[7:0];
      sensor_regs_pkg::IDX_T1:    rb = s_q.temp[15:8];
      sensor_regs_pkg::IDX_T2:    rb = s_q.temp[23:16];
      sensor_regs_pkg::IDX_TM0:   rb = sens.time_count[7:0];
      sensor_regs_pkg::IDX_TM1:   rb = sens.time_count[15:8];
      sensor_regs_pkg::IDX_TM2:   rb = sens.time_count[23:16];
      sensor_regs_pkg::IDX_EVENT: rb = {6'h00, s_q.act, s_q.por};
      sensor_regs_pkg::IDX_INT:   rb = {4'h0, s_q.irq[2], 1'b0, s_q.irq[1:0]};
      sensor_regs_pkg::IDX_LEN0:  rb = s_q.cnt[7:0];
      sensor_regs_pkg::IDX_LEN1:  rb = {6'h00, s_q.cnt[9:8]};
      sensor_regs_pkg::IDX_PORT:  rb = port_b;
      sensor_regs_pkg::IDX_WTM0:  rb = s_q.wtm[7:0];
      sensor_regs_pkg::IDX_WTM1:  rb = {7'h00, s_q.wtm[8]};
      sensor_regs_pkg::IDX_CFG1:  rb = {3'h0, s_q.cfg1};
      sensor_regs_pkg::IDX_CFG2:  rb = {3'h0, s_q.cfg2};
      default: begin
        // Unmapped index answers with an error
        known = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Frame content selection
  // ----------------------------------------------------------------
  always_comb begin
    sample = sens.p_valid | sens.t_valid;

    filt   = (s_q.cfg2[4:3] == sensor_regs_pkg::DSEL_FILT);
    fp     = filt ? sens.p_filt : sens.p_raw;
    ft     = filt ? sens.t_filt : sens.t_raw;

    use_p  = s_q.cfg1[sensor_regs_pkg::C1_PRESS] & sens.p_valid;
    use_t  = s_q.cfg1[sensor_regs_pkg::C1_TEMP] & sens.t_valid;
    msk    = 7'((8'h01 << s_q.cfg2[2:0]) - 8'h01);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d    = s_q;
    setup  = psel & ~penable;
    rd_acc = psel & penable & ~pwrite & known;
    wr_acc = psel & penable & pwrite & known;

    full   = (s_q.cnt == 10'(DEPTH));
    pop    = rd_acc && (idx == sensor_regs_pkg::IDX_PORT) && (s_q.cnt != 10'h000);

    push   = 1'b0;
    we     = 1'b0;
    wdat   = s_q.frame[7:0];

    // Read data is captured in setup so the access phase sees a flop
    if (setup) begin
      s_d.prdata = {24'h000000, rb};
      s_d.slverr = ~known;
    end

    // Side effects of completed reads; event sets below win
    if (rd_acc) begin
      unique case (idx)
        sensor_regs_pkg::IDX_ERR: begin
          s_d.cmd_err  = 1'b0;
          s_d.conf_err = 1'b0;
        end
        sensor_regs_pkg::IDX_P0, sensor_regs_pkg::IDX_P1,
        sensor_regs_pkg::IDX_P2: begin
          s_d.drdy_p = 1'b0;
        end
        sensor_regs_pkg::IDX_T0, sensor_regs_pkg::IDX_T1,
        sensor_regs_pkg::IDX_T2: begin
          s_d.drdy_t = 1'b0;
        end
        sensor_regs_pkg::IDX_EVENT: begin
          s_d.por = 1'b0;
          s_d.act = 1'b0;
        end
        sensor_regs_pkg::IDX_INT: begin
          s_d.irq = 3'h0;
        end
        sensor_regs_pkg::IDX_PORT: begin
          // Time frame advances only once the data has run dry
          if (!pop && s_q.cfg1[sensor_regs_pkg::C1_TIME] &&
              s_q.tidx != sensor_regs_pkg::TIME_DONE) begin
            s_d.tidx = s_q.tidx + 3'h1;
          end
        end
        default: begin
          // Plain reads have no side effect
        end
      endcase
    end

    // Register writes; read-only targets ignore the data
    if (wr_acc) begin
      unique case (idx)
        sensor_regs_pkg::IDX_WTM0: begin
          if (pstrb[0]) begin
            s_d.wtm[7:0] = pwdata[7:0];
          end
        end
        sensor_regs_pkg::IDX_WTM1: begin
          if (pstrb[0]) begin
            s_d.wtm[8] = pwdata[0];
          end
        end
        sensor_regs_pkg::IDX_CFG1: begin
          if (pstrb[0]) begin
            s_d.cfg1 = pwdata[4:0];
          end
        end
        sensor_regs_pkg::IDX_CFG2: begin
          if (pstrb[0]) begin
            s_d.cfg2 = pwdata[4:0];
          end
        end
        default: begin
          // Writes elsewhere have no effect
        end
      endcase
    end

    // Sticky events from the sensor core
    if (sens.cmd_fail) s_d.cmd_err = 1'b1;
    if (sens.conf_fault && sens.power_mode == sensor_regs_pkg::MODE_NORMAL) begin
      s_d.conf_err = 1'b1;
    end
    if (sens.soft_reset) s_d.por = 1'b1;
    if (psel && penable && sens.conv_active) s_d.act = 1'b1;

    // New results
    if (sens.p_valid) begin
      s_d.press  = sens.p_raw;
      s_d.drdy_p = 1'b1;
    end

    if (sens.t_valid) begin
      s_d.temp   = sens.t_raw;
      s_d.drdy_t = 1'b1;
    end

    if (sample && sens.drdy_en) s_d.irq[2] = 1'b1;

    // Frame capture; a sample arriving mid-push is skipped
    if (sample && s_q.cfg1[sensor_regs_pkg::C1_MODE]) begin
      s_d.sub = s_q.sub + 7'h01;

      if (((s_q.sub & msk) == 7'h00) && (use_p || use_t) &&
          s_q.seq == sensor_regs_pkg::SEQ_IDLE) begin
        s_d.frame = 56'h0;
        s_d.frame[7:0] = sensor_regs_pkg::HDR_DATA
                       | (use_p ? sensor_regs_pkg::HDR_PRESS : 8'h00)
                       | (use_t ? sensor_regs_pkg::HDR_TEMP : 8'h00);

        if (use_p) begin
          s_d.frame[31:8] = fp;
          if (use_t) s_d.frame[55:32] = ft;
        end else begin
          s_d.frame[31:8] = ft;
        end

        s_d.flen = (use_p && use_t) ? 3'h7 : 3'h4;
        s_d.fidx = 3'h0;
        s_d.seq  = sensor_regs_pkg::SEQ_PUSH;
      end
    end

    // Push one frame byte per cycle
    unique case (s_q.seq)
      sensor_regs_pkg::SEQ_PUSH: begin
        wdat = s_q.frame[8*s_q.fidx +: 8];
        push = ~(full & s_q.cfg1[sensor_regs_pkg::C1_STOP]);
        s_d.fidx = s_q.fidx + 3'h1;
        if (s_q.fidx == s_q.flen - 3'h1) s_d.seq = sensor_regs_pkg::SEQ_IDLE;
      end
      sensor_regs_pkg::SEQ_IDLE: begin
        push = 1'b0;
      end
    endcase

    // Pointer and count upkeep
    ovw = push & full & ~pop;
    if (push) begin
      we       = 1'b1;
      s_d.wr   = s_q.wr + 9'h001;
      s_d.tidx = 3'h0; // Fresh data re-arms the time frame
    end
    if (pop || ovw) s_d.rd = s_q.rd + 9'h001;

    s_d.cnt = s_q.cnt + {9'h000, push & ~ovw} - {9'h000, pop};

    // Level conditions
    if (sens.fwm_en && s_q.cnt >= {1'b0, s_q.wtm}) s_d.irq[0] = 1'b1;
    if (sens.ffull_en && full) s_d.irq[1] = 1'b1;
  end

  // ----------------------------------------------------------------
  // FIFO storage, no reset needed on data
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[s_q.wr] <= wdat;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q       <= '0;

      s_q.por   <= 1'b1; // Power-up leaves the flag raised
      s_q.press <= sensor_regs_pkg::RST_RESULT;
      s_q.temp  <= sensor_regs_pkg::RST_RESULT;
      s_q.wtm   <= sensor_regs_pkg::RST_WTM;
      s_q.cfg1  <= sensor_regs_pkg::RST_CFG1;
      s_q.cfg2  <= sensor_regs_pkg::RST_CFG2;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : sensor_status_fifo_regs

// file: core/sensor_regs_pkg.sv
// Constants and carriers for the sensor status, result and FIFO register section
package sensor_regs_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_REV   = 8'h01;
  localparam logic [7:0] IDX_ERR   = 8'h02;
  localparam logic [7:0] IDX_FLAGS = 8'h03;
  localparam logic [7:0] IDX_P0    = 8'h04;
  localparam logic [7:0] IDX_P1    = 8'h05;
  localparam logic [7:0] IDX_P2    = 8'h06;
  localparam logic [7:0] IDX_T0    = 8'h07;
  localparam logic [7:0] IDX_T1    = 8'h08;
  localparam logic [7:0] IDX_T2    = 8'h09;
  localparam logic [7:0] IDX_TM0   = 8'h0C;
  localparam logic [7:0] IDX_TM1   = 8'h0D;
  localparam logic [7:0] IDX_TM2   = 8'h0E;
  localparam logic [7:0] IDX_EVENT = 8'h10;
  localparam logic [7:0] IDX_INT   = 8'h11;
  localparam logic [7:0] IDX_LEN0  = 8'h12;
  localparam logic [7:0] IDX_LEN1  = 8'h13;
  localparam logic [7:0] IDX_PORT  = 8'h14;
  localparam logic [7:0] IDX_WTM0  = 8'h15;
  localparam logic [7:0] IDX_WTM1  = 8'h16;
  localparam logic [7:0] IDX_CFG1  = 8'h17;
  localparam logic [7:0] IDX_CFG2  = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ERR_FATAL  = 0;
  localparam int ERR_CMD    = 1;
  localparam int ERR_CONF   = 2;
  localparam int FLG_CMDRDY = 4;
  localparam int FLG_DRDYP  = 5;
  localparam int FLG_DRDYT  = 6;
  localparam int EV_POR     = 0;
  localparam int EV_ACT     = 1;
  localparam int INT_FWM    = 0;
  localparam int INT_FFULL  = 1;
  localparam int INT_DRDY   = 3;
  localparam int C1_MODE    = 0;
  localparam int C1_STOP    = 1;
  localparam int C1_TIME    = 2;
  localparam int C1_PRESS   = 3;
  localparam int C1_TEMP    = 4;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [23:0] RST_RESULT = 24'h800000;
  localparam logic [8:0]  RST_WTM    = 9'h001;
  localparam logic [4:0]  RST_CFG1   = 5'h02;
  localparam logic [4:0]  RST_CFG2   = 5'h02;
  localparam logic [1:0]  MODE_NORMAL = 2'h3;
  localparam logic [1:0]  DSEL_FILT   = 2'h1;
  localparam logic [7:0]  HDR_DATA    = 8'h80;
  localparam logic [7:0]  HDR_PRESS   = 8'h04;
  localparam logic [7:0]  HDR_TEMP    = 8'h10;
  localparam logic [7:0]  HDR_TIME    = 8'hA0;
  localparam logic [7:0]  BYTE_EMPTY  = 8'h00;
  localparam logic [2:0]  TIME_DONE   = 3'h4;

  // ----------------------------------------------------------------
  // Sensor core inputs to this section
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        p_valid;     // Pressure strobe
    logic        t_valid;     // Temperature strobe
    logic [23:0] p_raw;       // Unfiltered pressure
    logic [23:0] p_filt;      // Filtered pressure
    logic [23:0] t_raw;       // Unfiltered temperature
    logic [23:0] t_filt;      // Filtered temperature
    logic [23:0] time_count;  // Sensor time
    logic        conv_active; // Conversion in progress
    logic        cmd_busy;    // Command decoder busy
    logic        cmd_fail;    // Command failed
    logic        conf_fault;  // Config fault
    logic        fatal;       // Fatal error level
    logic        soft_reset;  // Soft reset done
    logic [1:0]  power_mode;  // Power mode
    logic        fwm_en;      // Watermark enable
    logic        ffull_en;    // Full enable
    logic        drdy_en;     // Data ready enable
  } sensor_in_t;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_PUSH = 1'b1
  } seq_t;

endpackage : sensor_regs_pkg

// file: bench/sensor_regs_checker.sv
// Port assertions for the sensor register section
`timescale 1ns/1ps
module sensor_regs_checker #(
  parameter int         DEPTH    = 512,
  parameter logic [7:0] REVISION = 8'h5A
) (
  // Clock and reset
  input wire logic                        core_clk,
  input wire logic                        resetn,
  // APB slave side
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [9:0]                  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // Sensor core side
  input wire sensor_regs_pkg::sensor_in_t sens,
  input wire logic [2:0]                  irq_flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  logic acc;     // Access phase
  logic rd_acc;  // Read access phase
  logic no_en;   // All interrupt sources masked, pressure strobe low
  assign acc = psel && penable;
  assign rd_acc = acc && !pwrite;
  assign no_en = !sens.fwm_en && !sens.ffull_en && !sens.drdy_en && !sens.p_valid;
  AST_READY: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_ERR_IDLE: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access phase");
  AST_UNMAPPED: assert property (acc && paddr[9:2] == 8'h0A |-> pslverr)
    else $error("no error on unmapped index");
  // Read data may only move after a setup cycle
  AST_RDATA_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved without setup");
  AST_REV: assert property (rd_acc && paddr[9:2] == 8'h01 |-> prdata == {24'h0, REVISION})
    else $error("revision read wrong");
  AST_CMD_RDY: assert property (
    rd_acc && paddr[9:2] == 8'h03 && $stable(sens.cmd_busy)
    && sens.cmd_busy == $past(sens.cmd_busy, 2) && sens.cmd_busy == $past(sens.cmd_busy, 3)
    |-> prdata[4] == !sens.cmd_busy) else $error("ready bit wrong");
  AST_DRDY_IRQ: assert property (sens.p_valid && sens.drdy_en |-> ##[1:2] irq_flags[2])
    else $error("data ready flag missing");
  AST_FWM_MASK: assert property (
    $rose(irq_flags[0]) |-> $past(sens.fwm_en) || $past(sens.fwm_en, 2))
    else $error("watermark flag without enable");
  AST_INT_CLEAR: assert property (rd_acc && paddr[9:2] == 8'h11 && no_en |=> irq_flags == 3'h0)
    else $error("status not cleared by read");
  // --------------------------------------------------------------
  // Coverage of main scenarios
  // --------------------------------------------------------------
  cover property (acc && pslverr);
  cover property ($rose(irq_flags[1]));
  cover property (rd_acc && paddr[9:2] == 8'h14);
endmodule : sensor_regs_checker

// file: bench/apb_host.sv
// Host model: APB master, one transfer at a time
`timescale 1ns/1ps
module apb_host (
  // Clock
  input  wire logic        core_clk,
  // APB request
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic [9:0]       paddr = 10'h000,
  output logic [31:0]      pwdata = 32'h0,
  output logic [3:0]       pstrb = 4'hF,
  // APB answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // One transfer, entered just after a rising edge; one idle cycle follows
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    // Hold the request until pready is seen
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : xfer
endmodule : apb_host

// file: bench/tb_top.sv
// Self-checking bench for the sensor register section
`timescale 1ns/1ps
module tb_top;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [9:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] irq_flags;
  sensor_regs_pkg::sensor_in_t sens;
  int n_errors, total_checks, cycles, seed;
  logic [7:0] exp_q[$];
  localparam logic [7:0] REV = 8'h3C;  // Arbitrary revision code
  localparam logic [7:0] RI[17] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18};
  localparam logic [7:0] RV[17] = '{REV, 8'h00, 8'h10, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00,
    8'h80, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h02};
  sensor_status_fifo_regs #(.REVISION(REV)) i_dut (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sens(sens),
    .irq_flags(irq_flags));
  apb_host i_host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
    i_host.xfer(1'b1, idx, d, rd, err);
  endtask : wr8
  task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
    i_host.xfer(1'b0, idx, 8'h00, rd, err);
    chk(what, exp, rd[7:0]);
  endtask : rdc
  // Random sample pulse, then settle
  task automatic sample();
    sens.p_raw <= 24'($random(seed));
    sens.p_filt <= 24'($random(seed));
    sens.t_raw <= 24'($random(seed));
    sens.t_filt <= 24'($random(seed));
    sens.p_valid <= 1'b1;
    sens.t_valid <= 1'b1;
    @(posedge core_clk);
    sens.p_valid <= 1'b0;
    sens.t_valid <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask : sample
  // Push one frame and pop it back
  task automatic frame(input logic [4:0] c1, input logic [1:0] sel);
    logic [23:0] p, t, tm;
    wr8(8'h17, {3'h0, c1});
    wr8(8'h18, {3'h0, sel, 3'h0});
    sample();
    p = (sel == 2'h1) ? sens.p_filt : sens.p_raw;
    t = (sel == 2'h1) ? sens.t_filt : sens.t_raw;
    tm = sens.time_count;
    exp_q = {};
    if (c1[0]) exp_q.push_back(8'h80 | (c1[3] ? 8'h04 : 8'h00) | (c1[4] ? 8'h10 : 8'h00));
    if (c1[0] && c1[3]) exp_q = {exp_q, p[7:0], p[15:8], p[23:16]};
    if (c1[0] && c1[4]) exp_q = {exp_q, t[7:0], t[15:8], t[23:16]};
    rdc("fill", 8'h12, 8'(exp_q.size()));
    if (c1[0] && c1[2]) exp_q = {exp_q, 8'hA0, tm[7:0], tm[15:8], tm[23:16]};
    exp_q.push_back(8'h00);
    foreach (exp_q[i]) rdc("port", 8'h14, exp_q[i]);
    rdc("drained", 8'h12, 8'h00);
  endtask : frame
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // --------------------------------------------------------------
  // Clock and hang guard
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      finish_test();
    end
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 32'h6618e1bc;
    sens = '0;
    sens.fwm_en = 1'b1;
    sens.ffull_en = 1'b1;
    sens.drdy_en = 1'b1;
    sens.time_count = 24'($random(seed));
    resetn = 1'b0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    foreach (RI[i]) rdc("reset value", RI[i], RV[i]);
    rdc("event cleared", 8'h10, 8'h00);
    wr8(8'h06, 8'h11);
    rdc("read-only", 8'h06, 8'h80);
    i_host.xfer(1'b0, 8'h0A, 8'h00, rd, err);
    chk("unmapped", 8'h01, {7'h0, err});
    $display("done registers");
    sens.cmd_fail <= 1'b1;
    sens.conf_fault <= 1'b1;
    @(posedge core_clk);
    sens.cmd_fail <= 1'b0;
    sens.conf_fault <= 1'b0;
    rdc("errors", 8'h02, 8'h02);
    rdc("errors", 8'h02, 8'h00);
    sens.power_mode <= 2'h3;
    sens.conf_fault <= 1'b1;
    @(posedge core_clk);
    sens.conf_fault <= 1'b0;
    rdc("conf", 8'h02, 8'h04);
    rdc("conf", 8'h02, 8'h00);
    $display("done errors");
    sample();
    rdc("flags", 8'h03, 8'h70);
    rdc("p0", 8'h04, sens.p_raw[7:0]);
    rdc("flags", 8'h03, 8'h50);
    rdc("p1", 8'h05, sens.p_raw[15:8]);
    rdc("p2", 8'h06, sens.p_raw[23:16]);
    rdc("t1", 8'h08, sens.t_raw[15:8]);
    rdc("flags", 8'h03, 8'h10);
    rdc("t0", 8'h07, sens.t_raw[7:0]);
    rdc("t2", 8'h09, sens.t_raw[23:16]);
    rdc("tm0", 8'h0C, sens.time_count[7:0]);
    rdc("tm1", 8'h0D, sens.time_count[15:8]);
    rdc("tm2", 8'h0E, sens.time_count[23:16]);
    sens.cmd_busy <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdc("busy", 8'h03, 8'h00);
    sens.cmd_busy <= 1'b0;
    sens.conv_active <= 1'b1;
    rdc("rev", 8'h01, REV);
    sens.conv_active <= 1'b0;
    rdc("conversion", 8'h10, 8'h02);
    $display("done results");
    wr8(8'h15, 8'h07);
    wr8(8'h16, 8'h00);
    rdc("int", 8'h11, 8'h08);
    frame(5'h1D, 2'h0);
    frame(5'h09, 2'h1);
    frame(5'h11, 2'h2);
    frame(5'h19, 2'h3);
    frame(5'h18, 2'h1);
    $display("done frames");
    wr8(8'h17, 8'h19);
    wr8(8'h18, 8'h01);
    repeat (4) sample();
    rdc("subsample", 8'h12, 8'd14);
    wr8(8'h18, 8'h00);
    repeat (80) sample();
    rdc("full low", 8'h12, 8'h00);
    rdc("full high", 8'h13, 8'h02);
    rdc("int", 8'h11, 8'h0B);
    sens.fwm_en <= 1'b0;
    sens.ffull_en <= 1'b0;
    sens.drdy_en <= 1'b0;
    rdc("int", 8'h11, 8'h03);
    rdc("masked", 8'h11, 8'h00);
    $display("done fifo");
    finish_test();
  end
endmodule : tb_top
bind sensor_status_fifo_regs sensor_regs_checker #(.DEPTH(DEPTH), .REVISION(REVISION)) i_chk (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sens(sens), .irq_flags(irq_flags));
